/* hdl/pixel_balance_cfg.svh */
// Register map, reset values and pipeline figures of the pixel datapath
`ifndef PIXEL_BALANCE_CFG_SVH
`define PIXEL_BALANCE_CFG_SVH
// Register indices on the local port
`define ADR_LEFT  4'h0
`define ADR_RIGHT 4'h1
`define ADR_SHIFT 4'h2
`define ADR_MODE  4'h3
`define ADR_STAT  4'h4
`define ADR_ACT   4'h5
`define ADR_REF   4'h8
// Status fields
`define ST_SHIFT  0
`define ST_MODE   2
`define ST_PEND   3
`define ST_RANGE  4
// Reset values: calibrated offsets and their stored references
`define RST_LEFT  8'h19
`define RST_RIGHT 8'h18
`define RST_REF   64'h0018_0000_0019_0000
// Offset setting shift: 4 setting steps per 10-bit output code (setting >> 2)
`define OFS_SH    2
// Pixel latency in clock cycles, same for both channels
`define LAT       2
`endif

/* hdl/pixel_balance_pkg.sv */
// Types shared by the pixel offset and shift datapath
package pixel_balance_pkg;
   typedef enum logic [1:0] {SHIFT_NONE, SHIFT_ONCE, SHIFT_TWICE} shift_t;
   typedef enum logic {MODE_10BIT, MODE_8BIT} out_mode_t;
endpackage

/* hdl/ref_store.sv */
// Reference offset bytes and the registered read port of the block
`timescale 1ns/1ps
`include "pixel_balance_cfg.svh"
module ref_store
   import pixel_balance_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Access
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [2:0]  idx,
   input  wire logic [7:0]  wbyte,
   input  wire logic        reg_hit,
   input  wire logic [15:0] reg_word,
   output logic      [15:0] rdata_q
);
   localparam logic [63:0] REF_INIT = `RST_REF;
   logic [7:0] mem_q [DEPTH];
   wire  [7:0] mem_rd = mem_q[idx];

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= REF_INIT[i*8 +: 8];
         end
      end else if (wr) begin
         mem_q[idx] <= wbyte;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rdata_q <= 16'h0000;
      end else if (rd) begin
         rdata_q <= reg_hit ? reg_word : {8'h00, mem_rd};
      end else begin
         rdata_q <= 16'h0000;
      end
   end
endmodule

/* hdl/pixel_shifter.sv */
// Digital shift with saturation and output width selection, one channel
`timescale 1ns/1ps
module pixel_shifter
   import pixel_balance_pkg::*;
#(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         reset_n,
   // Sample and settings
   input  wire logic [W-1:0] sample,
   input  wire logic [1:0]   shift,
   input  wire logic         mode,
   output logic      [W-1:0] pix_q
);
   wire         sat1    = sample[W-1];
   wire         sat2    = |sample[W-1:W-2];
   wire [W-1:0] once_w  = sat1 ? '1 : {sample[W-2:0], 1'b0};
   wire [W-1:0] twice_w = sat2 ? '1 : {sample[W-3:0], 2'b00};
   // Code 3 never reaches here; it falls back to the plain sample
   wire [W-1:0] wide_w  = (shift == SHIFT_ONCE)  ? once_w :
                          (shift == SHIFT_TWICE) ? twice_w :
                          sample;
   // 8-bit output is the 10-bit result with its two low bits dropped
   wire [W-1:0] pix_d   = (mode == MODE_8BIT) ? (wide_w >> 2) :
                          wide_w;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pix_q <= '0;
      end else begin
         pix_q <= pix_d;
      end
   end
endmodule

/* hdl/pixel_shift_offset_balance.sv */
// Two-channel pixel offset, digital shift and reference store
//
// Summary of operation
// - left and right offsets are separate registers, each with own write
// - offset writes take 0 to 255; a nonzero upper byte is refused
// - reference offset bytes at addresses 8..15 read back, left side first
// - in 8-bit output, offset setting +16 raises output by one
// - shift picks which converter bit group forms the pixel: x1, x2, x4
// - shift register takes none, once or twice; other codes ignored
// - 10-bit output with no shift passes all ten bits, reset default
// - 10-bit shift once sends bits 8..0 then a zero
// - shift once saturates to all ones when bit 9 is set
// - 10-bit shift twice sends bits 7..0 then two zeros
// - shift twice saturates to all ones when bit 9 or 8 is set
// - in 10-bit output, offset setting +4 raises output by one
// - 8-bit output with no shift sends bits 9..2
// - reset offsets are the calibrated values giving offset two
`timescale 1ns/1ps
`include "pixel_balance_cfg.svh"
module pixel_shift_offset_balance
   import pixel_balance_pkg::*;
#(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         reset_n,
   // Register port
   input  wire logic [3:0]   addr,
   input  wire logic [15:0]  wdata,
   input  wire logic         wr,
   input  wire logic         rd,
   output wire logic [15:0]  rdata,
   // Converter samples
   input  wire logic         fv_in,
   input  wire logic         lv_in,
   input  wire logic [W-1:0] left_in,
   input  wire logic [W-1:0] right_in,
   // Video output
   output wire logic         fv_out,
   output wire logic         lv_out,
   output wire logic [W-1:0] left_out,
   output wire logic [W-1:0] right_out
);
   //------------------------------------------------------------------
   // Address decode
   //------------------------------------------------------------------
   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction

   wire wr_left  = wr && hit(addr, `ADR_LEFT);
   wire wr_right = wr && hit(addr, `ADR_RIGHT);
   wire wr_shift = wr && hit(addr, `ADR_SHIFT);
   wire wr_mode  = wr && hit(addr, `ADR_MODE);
   wire wr_stat  = wr && hit(addr, `ADR_STAT);
   wire wr_ref   = wr && addr[3];
   wire upper_ok = (wdata[15:8] == 8'h00);
   wire shift_ok = (wdata[15:2] == 14'h0000) && (wdata[1:0] != 2'b11);
   wire range_bad = (wr_left || wr_right) && !upper_ok;

   //------------------------------------------------------------------
   // Settings written by the host
   //------------------------------------------------------------------
   logic [7:0] left_ofs_q;
   logic [7:0] right_ofs_q;
   logic [1:0] shift_q;
   logic       mode_q;
   logic       range_err_q;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         left_ofs_q  <= `RST_LEFT;
         right_ofs_q <= `RST_RIGHT;
         shift_q     <= SHIFT_NONE;
         mode_q      <= MODE_10BIT;
      end else begin
         if (wr_left && upper_ok) begin
            left_ofs_q <= wdata[7:0];
         end
         if (wr_right && upper_ok) begin
            right_ofs_q <= wdata[7:0];
         end
         if (wr_shift && shift_ok) begin
            shift_q <= wdata[1:0];
         end
         if (wr_mode) begin
            mode_q <= wdata[0];
         end
      end
   end

   // Refused offset writes leave a sticky flag; a new refusal beats the clear
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         range_err_q <= 1'b0;
      end else if (range_bad) begin
         range_err_q <= 1'b1;
      end else if (wr_stat && wdata[`ST_RANGE]) begin
         range_err_q <= 1'b0;
      end
   end

   //------------------------------------------------------------------
   // Active settings, swapped only while no frame is in flight
   //------------------------------------------------------------------
   logic [7:0] act_left_q;
   logic [7:0] act_right_q;
   logic [1:0] act_shift_q;
   logic       act_mode_q;
   logic       fv_s1_q;
   logic       lv_s1_q;
   logic       fv_out_q;
   logic       lv_out_q;

   // Waiting for the pipe to drain keeps a frame's tail on old settings
   wire idle    = !fv_in && !fv_s1_q && !fv_out_q;
   wire pending = (act_left_q != left_ofs_q) || (act_right_q != right_ofs_q)
                  || (act_shift_q != shift_q) || (act_mode_q != mode_q);

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         act_left_q  <= `RST_LEFT;
         act_right_q <= `RST_RIGHT;
         act_shift_q <= SHIFT_NONE;
         act_mode_q  <= MODE_10BIT;
      end else if (idle) begin
         act_left_q  <= left_ofs_q;
         act_right_q <= right_ofs_q;
         act_shift_q <= shift_q;
         act_mode_q  <= mode_q;
      end
   end

   //------------------------------------------------------------------
   // Stage 1: offset add with saturation
   //------------------------------------------------------------------
   wire [W-1:0] ch_in  [2];
   wire [7:0]   ch_ofs [2];
   wire [W-1:0] s1_d   [2];
   wire [W-1:0] pix_w  [2];
   logic [W-1:0] s1_q  [2];

   assign ch_in[0]  = left_in;
   assign ch_in[1]  = right_in;
   assign ch_ofs[0] = act_left_q;
   assign ch_ofs[1] = act_right_q;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         // A quarter of the setting in 10-bit codes: 4 per code at 10 bits,
         // 16 per code once two bits are dropped for 8-bit output
         wire [W:0] sum = {1'b0, ch_in[g]} +
                          (W+1)'(ch_ofs[g] >> `OFS_SH);
         assign s1_d[g] = sum[W] ? '1 : sum[W-1:0];
         pixel_shifter #(.W(W)) u_shift (
            .clock   (clock),
            .reset_n (reset_n),
            .sample  (s1_q[g]),
            .shift   (act_shift_q),
            .mode    (act_mode_q),
            .pix_q   (pix_w[g])
         );
      end
   endgenerate

   // Both channels and the frame flags share the same two stages
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int c = 0; c < 2; c++) begin
            s1_q[c] <= '0;
         end
         fv_s1_q  <= 1'b0;
         lv_s1_q  <= 1'b0;
         fv_out_q <= 1'b0;
         lv_out_q <= 1'b0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            s1_q[c] <= s1_d[c];
         end
         fv_s1_q  <= fv_in;
         lv_s1_q  <= lv_in;
         fv_out_q <= fv_s1_q;
         lv_out_q <= lv_s1_q;
      end
   end

   assign fv_out    = fv_out_q;
   assign lv_out    = lv_out_q;
   assign left_out  = pix_w[0];
   assign right_out = pix_w[1];

   //------------------------------------------------------------------
   // Read mux and reference store
   //------------------------------------------------------------------
   wire [15:0] stat_w = {11'h000, range_err_q, pending, mode_q, shift_q};
   wire [15:0] act_w  = {act_right_q, act_left_q};
   wire [15:0] reg_word =
      hit(addr, `ADR_LEFT)  ? {8'h00, left_ofs_q}  :
      hit(addr, `ADR_RIGHT) ? {8'h00, right_ofs_q} :
      hit(addr, `ADR_SHIFT) ? {14'h0000, shift_q}  :
      hit(addr, `ADR_MODE)  ? {15'h0000, mode_q}   :
      hit(addr, `ADR_STAT)  ? stat_w :
      hit(addr, `ADR_ACT)   ? act_w  : 16'h0000;

   ref_store #(.DEPTH(8)) u_ref (
      .clock    (clock),
      .reset_n  (reset_n),
      .wr       (wr_ref),
      .rd       (rd),
      .idx      (addr[2:0]),
      .wbyte    (wdata[7:0]),
      .reg_hit  (!addr[3]),
      .reg_word (reg_word),
      .rdata_q  (rdata)
   );

   //------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   ofs_refuse_a: assert property (
      wr_left && !upper_ok |=> $stable(left_ofs_q) && range_err_q)
      else $error("offset write with upper byte was taken");

   ofs_take_a: assert property (
      wr_left && upper_ok |=> left_ofs_q == $past(wdata[7:0])
                              && $stable(right_ofs_q))
      else $error("left offset write wrong or touched right");

   right_take_a: assert property (
      wr_right && upper_ok |=> right_ofs_q == $past(wdata[7:0])
                               && $stable(left_ofs_q))
      else $error("right offset write wrong or touched left");

   shift_cmd_a: assert property (
      wr_shift |=> shift_q == ($past(shift_ok) ? $past(wdata[1:0])
                                               : $past(shift_q)))
      else $error("shift setting update wrong");

   frame_hold_a: assert property (
      fv_in || fv_s1_q || fv_out_q |=> $stable(act_shift_q)
         && $stable(act_left_q) && $stable(act_mode_q))
      else $error("settings changed inside a frame");

   pipe_lat_a: assert property (
      $rose(fv_in) |-> ##`LAT $rose(fv_out) ##0 lv_out == $past(lv_in, 2))
      else $error("frame flag latency wrong");

   ofs_add_a: assert property (
      fv_in && left_in < 10'h300 |=>
         s1_q[0] == $past(left_in) + 10'($past(act_left_q) >> 2))
      else $error("offset not added as a quarter of the setting");

   plain_ten_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_NONE && act_mode_q == MODE_10BIT
      |=> left_out == $past(s1_q[0]) && right_out == $past(s1_q[1]))
      else $error("unshifted 10-bit pixel altered");

   once_even_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_ONCE && act_mode_q == MODE_10BIT
      && !s1_q[0][9] |=> left_out == {$past(s1_q[0][8:0]), 1'b0})
      else $error("shift once bit group wrong");

   once_sat_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_ONCE && act_mode_q == MODE_10BIT
      && s1_q[1][9] |=> right_out == 10'h3FF)
      else $error("shift once did not saturate");

   twice_bits_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_TWICE && act_mode_q == MODE_10BIT
      && s1_q[0][9:8] == 2'b00 |=> left_out == {$past(s1_q[0][7:0]), 2'b00})
      else $error("shift twice bit group wrong");

   twice_sat_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_TWICE && act_mode_q == MODE_10BIT
      && s1_q[1][9:8] != 2'b00 |=> right_out == 10'h3FF)
      else $error("shift twice did not saturate");

   eight_drop_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_NONE && act_mode_q == MODE_8BIT
      |=> right_out == {2'b00, $past(s1_q[1][9:2])})
      else $error("8-bit output does not carry bits 9..2");

   ref_read_a: assert property (
      wr_ref ##1 (rd && addr == $past(addr)) |=>
         rdata == {8'h00, $past(wdata[7:0], 2)})
      else $error("reference byte read back wrong");

   range_sticky_a: assert property (
      range_err_q && !(wr_stat && wdata[`ST_RANGE]) |=> range_err_q)
      else $error("range flag dropped without a clear");

   range_clear_a: assert property (
      wr_stat && wdata[`ST_RANGE] && !range_bad |=> !range_err_q)
      else $error("range flag not cleared");

   right_refuse_a: assert property (
      wr_right && !upper_ok |=> $stable(right_ofs_q) && range_err_q)
      else $error("right offset write with upper byte was taken");

   right_add_a: assert property (
      fv_in && right_in < 10'h300 |=>
         s1_q[1] == $past(right_in) + 10'($past(act_right_q) >> 2))
      else $error("right offset not added as a quarter of the setting");

   act_take_a: assert property (
      idle |=> act_left_q == $past(left_ofs_q)
         && act_right_q == $past(right_ofs_q)
         && act_shift_q == $past(shift_q) && act_mode_q == $past(mode_q))
      else $error("settings not taken between frames");

   flag_lat_a: assert property (
      $past(reset_n, 2) |-> fv_out == $past(fv_in, 2)
         && lv_out == $past(lv_in, 2))
      else $error("frame or line flag latency wrong");

   shift_code_a: assert property (
      shift_q != 2'b11)
      else $error("shift setting holds the unused code");

   mode_take_a: assert property (
      wr_mode |=> mode_q == $past(wdata[0]))
      else $error("output mode write not taken");

   eight_zero_a: assert property (
      fv_s1_q && act_mode_q == MODE_8BIT
      |=> left_out[9:8] == 2'b00 && right_out[9:8] == 2'b00)
      else $error("8-bit output uses the top two bits");

   once_odd_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_ONCE && act_mode_q == MODE_10BIT
      |=> right_out[0] == 1'b0 || right_out == 10'h3FF)
      else $error("shift once gave an odd value");

   twice_mult_a: assert property (
      fv_s1_q && act_shift_q == SHIFT_TWICE && act_mode_q == MODE_10BIT
      |=> right_out[1:0] == 2'b00 || right_out == 10'h3FF)
      else $error("shift twice gave a value not a multiple of four");

   rdata_rest_a: assert property (
      !rd |=> rdata == 16'h0000)
      else $error("read data stood outside the answer cycle");
endmodule

/* sim/host_model.sv */
// Host side model: register port master and offset balancing arithmetic
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic        clock,
   // Register port
   output logic      [3:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [15:0] rdata
);
   initial begin
      addr  = 4'h0;
      wdata = 16'h0000;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask

   task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // Write then read one index with no gap between the two strobes
   task automatic write_read(input logic [3:0] a, input logic [15:0] d,
      output logic [15:0] q);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
      rd    <= 1'b1;
      @(posedge clock);
      rd    <= 1'b0;
      #1 q = rdata;
   endtask

   // Fraction bytes only round; low fraction byte cannot change the result
   function automatic logic [15:0] balance(input logic [7:0] ilo,
      input logic [7:0] ihi, input logic [7:0] fhi, input int o);
      int r;
      r = ihi * 256 + ilo + (fhi >= 8'h80);
      r = r + 16 * (o - 2);
      return 16'(r);
   endfunction
endmodule

/* sim/tb_top.sv */
// Self-checking bench of the pixel offset and shift datapath
`timescale 1ns/1ps
`include "pixel_balance_cfg.svh"
`define CHK(n, e, a) begin checks++; if ((e) !== (a)) begin \
   bad_count++; $display("FAIL %s expected %h seen %h", n, e, a); end end
module tb_top;
   import pixel_balance_pkg::*;
   logic        clock, reset_n, fv_in, lv_in, fv_out, lv_out, wr, rd;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, v;
   logic [9:0]  left_in, right_in, left_out, right_out;
   logic [7:0]  lofs, rofs;
   int          bad_count, checks, sh;
   bit          m8;

   host_model i_host_model (.clock(clock), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata));
   pixel_shift_offset_balance i_pixel_shift_offset_balance (
      .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .fv_in(fv_in), .lv_in(lv_in),
      .left_in(left_in), .right_in(right_in), .fv_out(fv_out),
      .lv_out(lv_out), .left_out(left_out), .right_out(right_out));

   // -------------------------------------------------------------
   // Expected pixel worked out independently of the design
   // -------------------------------------------------------------
   function automatic logic [9:0] ex(input logic [9:0] s,
      input logic [7:0] o);
      logic [10:0] t;
      logic [9:0]  q;
      t = s + o[7:2];
      q = t > 11'h3FF ? 10'h3FF : t[9:0];
      if (sh == 1) q = q[9] ? 10'h3FF : {q[8:0], 1'b0};
      if (sh == 2) q = (q[9] | q[8]) ? 10'h3FF : {q[7:0], 2'b00};
      return m8 ? q >> 2 : q;
   endfunction

   task automatic pix(input logic [9:0] l, input logic [9:0] r);
      @(posedge clock);
      fv_in    <= 1'b1;
      lv_in    <= 1'b1;
      left_in  <= l;
      right_in <= r;
      repeat (2) @(posedge clock);
      #1;
      `CHK("fv_out", 1'b1, fv_out)
      `CHK("lv_out", 1'b1, lv_out)
      `CHK("left_out", ex(l, lofs), left_out)
      `CHK("right_out", ex(r, rofs), right_out)
   endtask

   // Settings only land once the pipeline has drained between frames
   task automatic idle;
      @(posedge clock);
      fv_in <= 1'b0;
      lv_in <= 1'b0;
      repeat (4) @(posedge clock);
      #1 `CHK("fv_out idle", 1'b0, fv_out)
      `CHK("lv_out idle", 1'b0, lv_out)
   endtask

   task automatic set(input logic [3:0] a, input logic [15:0] d);
      i_host_model.write_reg(a, d);
   endtask

   task automatic t_reset;
      for (int i = 0; i < 8; i++) begin
         i_host_model.read_reg(`ADR_REF + 4'(i), v);
         `CHK("ref", i==2 ? 16'h0019 : i==6 ? 16'h0018 : 16'h0, v)
      end
      i_host_model.read_reg(`ADR_LEFT, v);
      `CHK("left ofs", 16'h0019, v)
      i_host_model.read_reg(`ADR_RIGHT, v);
      `CHK("right ofs", 16'h0018, v)
      i_host_model.read_reg(4'h6, v);
      `CHK("unmapped", 16'h0000, v)
      i_host_model.write_read(`ADR_REF, 16'h005A, v);
      `CHK("ref write", 16'h005A, v)
      pix(10'h155, 10'h2AA);
   endtask

   task automatic t_offset;
      logic [15:0] a, b, c;
      i_host_model.read_reg(`ADR_REF + 4'h2, a);
      i_host_model.read_reg(`ADR_REF + 4'h3, b);
      i_host_model.read_reg(`ADR_REF + 4'h1, c);
      lofs = 8'(i_host_model.balance(a[7:0], b[7:0], c[7:0], 5));
      `CHK("left set", 8'h49, lofs)
      i_host_model.read_reg(`ADR_REF + 4'h6, a);
      i_host_model.read_reg(`ADR_REF + 4'h7, b);
      i_host_model.read_reg(`ADR_REF + 4'h5, c);
      rofs = 8'(i_host_model.balance(a[7:0], b[7:0], c[7:0], 5));
      `CHK("right set", 8'h48, rofs)
      set(`ADR_LEFT, {8'h00, lofs});
      set(`ADR_RIGHT, {8'h00, rofs});
      set(`ADR_MODE, 16'h0001);
      m8 = 1'b1;
      i_host_model.read_reg(`ADR_ACT, v);
      `CHK("act held", 16'h1819, v)
      idle();
      i_host_model.read_reg(`ADR_ACT, v);
      `CHK("act taken", {rofs, lofs}, v)
      pix(10'h100, 10'h0FC);
      set(`ADR_LEFT, 16'h0100);
      i_host_model.read_reg(`ADR_LEFT, v);
      `CHK("refused ofs", {8'h00, lofs}, v)
      set(`ADR_RIGHT, 16'h0200);
      i_host_model.read_reg(`ADR_RIGHT, v);
      `CHK("refused right", {8'h00, rofs}, v)
      i_host_model.read_reg(`ADR_STAT, v);
      `CHK("range flag", 1'b1, v[`ST_RANGE])
      set(`ADR_STAT, 16'h0010);
      i_host_model.read_reg(`ADR_STAT, v);
      `CHK("range clear", 1'b0, v[`ST_RANGE])
      lofs = 8'hFF;
      rofs = 8'h00;
      set(`ADR_LEFT, 16'h00FF);
      set(`ADR_RIGHT, 16'h0000);
      set(`ADR_MODE, 16'h0000);
      m8 = 1'b0;
      idle();
      pix(10'h3F0, 10'h3F0);
      pix(10'h011, 10'h011);
   endtask

   task automatic do_shift(input int s);
      sh = s;
      set(`ADR_SHIFT, 16'(s));
      for (int m = 0; m < 2; m++) begin
         m8 = m[0];
         set(`ADR_MODE, 16'(m));
         idle();
         pix(10'h0FF, 10'h100);
         pix(10'h1FF, 10'h200);
         pix(10'h3FF, 10'h0AB);
      end
   endtask

   task automatic t_shift;
      lofs = 8'h00;
      rofs = 8'h00;
      set(`ADR_LEFT, 16'h0000);
      set(`ADR_RIGHT, 16'h0000);
      do_shift(1);
      do_shift(2);
      do_shift(0);
      set(`ADR_SHIFT, 16'h0003);
      idle();
      i_host_model.read_reg(`ADR_STAT, v);
      `CHK("bad shift", 2'b00, v[1:0])
      pix(10'h123, 10'h321);
   endtask

   task automatic t_frame;
      m8 = 1'b0;
      set(`ADR_MODE, 16'h0000);
      idle();
      pix(10'h040, 10'h041);
      set(`ADR_SHIFT, 16'h0001);
      pix(10'h040, 10'h041);
      i_host_model.read_reg(`ADR_STAT, v);
      `CHK("pending", 1'b1, v[`ST_PEND])
      idle();
      sh = 1;
      pix(10'h040, 10'h041);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Whole run needs well under 2000 cycles
   initial begin
      #(25 * 5000);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      reset_n  = 1'b0;
      fv_in    = 1'b0;
      lv_in    = 1'b0;
      left_in  = 10'h000;
      right_in = 10'h000;
      lofs     = 8'h19;
      rofs     = 8'h18;
      sh       = 0;
      m8       = 1'b0;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      t_offset();
      t_shift();
      t_frame();
      tally_and_finish();
   end
endmodule
